/* common/ccdreg_consts.vh */
// register offsets, reset values and field widths of the control register bank
`ifndef CCDREG_CONSTS_VH
`define CCDREG_CONSTS_VH

// ****************************************************************
// serial frame layout
// ****************************************************************
`define CCDREG_ADDR_BITS 10
`define CCDREG_DATA_BITS 6

// ****************************************************************
// register offsets
// ****************************************************************
`define CCDREG_OP_MODE_LOW 10'h000
`define CCDREG_OP_MODE_HIGH 10'h001
`define CCDREG_VGA_GAIN_LOW 10'h002
`define CCDREG_VGA_GAIN_HIGH 10'h003
`define CCDREG_BLACK_LEVEL_LOW 10'h004
`define CCDREG_BLACK_LEVEL_HIGH 10'h005
`define CCDREG_AFE_CONTROL 10'h006
`define CCDREG_COLOR_GAIN_0 10'h007
`define CCDREG_COLOR_GAIN_3 10'h00a
`define CCDREG_INIT_VALUE_B 10'h010
`define CCDREG_SOFT_RESET 10'h017
`define CCDREG_OUTPUT_GATE 10'h018
`define CCDREG_UPDATE_LINE_LOW 10'h019
`define CCDREG_UPDATE_LINE_HIGH 10'h01a
`define CCDREG_HOLD_UPDATE 10'h01b
`define CCDREG_READBACK_ENABLE 10'h01c
`define CCDREG_DATA_OUT_PHASE 10'h01d
`define CCDREG_DATA_CLOCK_SELECT 10'h01e
`define CCDREG_INPUT_CLOCK_HALVE 10'h01f
`define CCDREG_RESTORE_DISABLE 10'h020
`define CCDREG_FIELD_PARITY_PRESET 10'h021
`define CCDREG_RETIME_PAIR_A 10'h022
`define CCDREG_RETIME_PAIR_B 10'h023
`define CCDREG_EXT_SYNC_ENABLE 10'h024
`define CCDREG_EXT_SYNC_POLARITY 10'h025
`define CCDREG_EXT_SYNC_SUSPEND 10'h026
`define CCDREG_LINE_FIELD_OUT_SELECT 10'h027
`define CCDREG_CLAMP_BLANK_OUT_SELECT 10'h028
`define CCDREG_TIMING_CORE_RUN 10'h029
`define CCDREG_FRAME_TRANSFER_MODE 10'h02a
`define CCDREG_INIT_VALUE_A 10'h02b
`define CCDREG_SHARED_CLAMP 10'h031
`define CCDREG_OUTPUT_DELAY 10'h032
`define CCDREG_OSCILLATOR_ENABLE 10'h033

// ****************************************************************
// reset values
// ****************************************************************
`define CCDREG_OP_MODE_RST 8'h10
`define CCDREG_VGA_GAIN_RST 10'h045
`define CCDREG_BLACK_LEVEL_RST 8'h80
`define CCDREG_FIELD_PARITY_RST 1'h1
`define CCDREG_SHARED_CLAMP_RST 1'h1
`define CCDREG_OUTPUT_DELAY_RST 2'h2
`define CCDREG_OSC_ENABLE_RST 1'h1

`endif

/* core/ccdreg_bank.v */
// serial-programmed control register bank with sl, sync and sensor-gate commit classes
`timescale 1ns/1ps
`include "ccdreg_consts.vh"

// Overview of operation
// - default commit at sync update line
// - listed registers commit on serial-load rise
// - substrate clear settings commit after gate line
// - soft reset bit restores all defaults except substrate clear config
// - output gate low forces outputs inactive
// - twelve-bit update line picks commit line
// - hold update blocks sync-class commits
// - readback enable drives data back serially
// - data clock select picks clock source
// - input clock halve divides by two
// - restore disable gates dc restore in blanking
// - field preset sets next field parity
// - retime bits retime blanking per pair
// - external sync enable, polarity, suspend
// - shared output pin mux selects
// - core run bit releases timing core
// - frame transfer repurposes sensor gates
// - shared clamp copies black clamp to dummy
// - output delay field and oscillator enable
// - ten address, six data bits, lsb first
// - serial load low auto-increments address
// - wide register commits only after high half
module ccdreg_bank (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // serial port pins, inputs asynchronous to sys_clk, outputs registered on sys_clk
  input wire serial_load,
  input wire serial_clock,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_out_en,
  // timing events from the timing core, same clock
  input wire horizontal_sync_fall,
  input wire sensor_gate_line_done,
  input wire [11:0] line_count,
  // substrate clear staging from the timing map, committed here
  input wire [5:0] subclr_stage,
  output reg [5:0] substrate_clear_cfg,
  // committed control values
  output reg [7:0] operation_mode,
  output reg [9:0] vga_gain,
  output reg [7:0] black_level,
  output reg [5:0] afe_control_mode,
  output reg [23:0] color_gain,
  output reg [5:0] data_out_phase,
  output reg output_gate,
  output reg data_clock_select,
  output reg input_clock_halve,
  output reg restore_disable,
  output reg field_parity_preset,
  output reg field_preset_pulse,
  output reg retime_pair_a,
  output reg retime_pair_b,
  output reg ext_sync_enable,
  output reg ext_sync_polarity,
  output reg ext_sync_suspend,
  output reg line_field_out_select,
  output reg clamp_blank_out_select,
  output reg timing_core_run,
  output reg frame_transfer_mode,
  output reg shared_clamp,
  output reg [1:0] output_delay,
  output reg oscillator_enable,
  output reg [5:0] init_value_a,
  output reg [5:0] init_value_b
);

  // ****************************************************************
  // serial pin synchronisers
  // ****************************************************************
  reg [2:0] sync1_reg; // first stage, read only by stage two
  reg [2:0] sync2_reg; // {load, clock, data}
  reg sclk_prev_reg; // for rising edge of serial clock
  reg sl_prev_reg; // for rising edge of serial load
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
      sclk_prev_reg <= 1'b0;
      sl_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {serial_load, serial_clock, serial_data_in};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[1];
      sl_prev_reg <= sync2_reg[2];
    end
  end
  wire sl_low = ~sync2_reg[2];
  wire sclk_rise = sync2_reg[1] & ~sclk_prev_reg & sl_low;
  wire sl_rise = sync2_reg[2] & ~sl_prev_reg;

  // ****************************************************************
  // shift engine: address phase then data words
  // ****************************************************************
  reg [4:0] bit_cnt_reg; // bits of current field
  reg addr_phase_reg; // 1 while taking the address
  reg [9:0] addr_reg; // current target address
  reg [5:0] shift_reg; // data assembly, lsb first
  reg word_done_reg; // one-cycle pulse: full word taken
  reg [9:0] word_addr_reg; // address of finished word
  reg [5:0] word_data_reg; // finished word
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg <= 5'h00;
      addr_phase_reg <= 1'b1;
      addr_reg <= 10'h000;
      shift_reg <= 6'h00;
      word_done_reg <= 1'b0;
      word_addr_reg <= 10'h000;
      word_data_reg <= 6'h00;
    end else begin
      word_done_reg <= 1'b0;
      if (!sl_low) begin
        // a partial word is dropped when the load ends early
        bit_cnt_reg <= 5'h00;
        addr_phase_reg <= 1'b1;
      end else if (sclk_rise) begin
        if (addr_phase_reg) begin
          addr_reg <= {sync2_reg[0], addr_reg[9:1]}; // lsb first
          if (bit_cnt_reg == 5'd9) begin
            addr_phase_reg <= 1'b0;
            bit_cnt_reg <= 5'h00;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end else begin
          shift_reg <= {sync2_reg[0], shift_reg[5:1]};
          if (bit_cnt_reg == 5'd5) begin
            // all six bits present: word is accepted
            word_done_reg <= 1'b1;
            word_addr_reg <= addr_reg;
            word_data_reg <= {sync2_reg[0], shift_reg[5:1]};
            addr_reg <= addr_reg + 10'h001; // next word, next address
            bit_cnt_reg <= 5'h00;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
      end
    end
  end

  // ****************************************************************
  // staging registers: written by serial words, committed later
  // ****************************************************************
  reg [5:0] stage_reg [0:63]; // staging image, index = low six address bits
  reg [63:0] dirty_reg; // entries written since last sync commit
  reg sl_pend_reg; // any data written since last sl rise
  reg sub_pend_reg; // substrate clear commit pending
  wire in_map = (word_addr_reg[9:6] == 4'h0);
  wire [5:0] widx = word_addr_reg[5:0];
  wire soft_reset_hit = word_done_reg && in_map && (word_addr_reg == `CCDREG_SOFT_RESET) && word_data_reg[0];

  // default image, used at reset and on soft reset
  function [5:0] dflt;
    input [5:0] i;
    begin
      case (i)
        6'h00: dflt = 6'h10;
        6'h02: dflt = 6'h05;
        6'h03: dflt = 6'h01;
        6'h05: dflt = 6'h02;
        6'h21: dflt = 6'h01;
        6'h31: dflt = 6'h01;
        6'h32: dflt = 6'h02;
        6'h33: dflt = 6'h01;
        default: dflt = 6'h00;
      endcase
    end
  endfunction

  // sync-class commit point: chosen line on a horizontal sync fall
  wire [11:0] update_line = {stage_reg[6'h1a], stage_reg[6'h19]};
  wire sync_commit = horizontal_sync_fall && (line_count == update_line) && !stage_reg[6'h1b][0];

  integer k;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < 64; k = k + 1) begin
        stage_reg[k] <= dflt(k[5:0]);
      end
      dirty_reg <= 64'h0;
      sl_pend_reg <= 1'b0;
      sub_pend_reg <= 1'b0;
    end else if (soft_reset_hit) begin
      for (k = 0; k < 64; k = k + 1) begin
        stage_reg[k] <= dflt(k[5:0]);
      end
      dirty_reg <= 64'h0;
      sl_pend_reg <= 1'b1;
      sub_pend_reg <= 1'b0;
    end else begin
      if (sync_commit) begin
        dirty_reg <= 64'h0;
      end
      if (sl_rise) begin
        sl_pend_reg <= 1'b0;
        sub_pend_reg <= 1'b1; // substrate settings wait for gate line
      end else if (sensor_gate_line_done) begin
        sub_pend_reg <= 1'b0;
      end
      if (word_done_reg && in_map) begin
        stage_reg[widx] <= word_data_reg;
        sl_pend_reg <= 1'b1;
        // a new write wins over a commit clearing in the same cycle
        dirty_reg[widx] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // committed registers
  // ****************************************************************
  // wide-register halves pair up only once the high half lands
  reg [5:0] vga_low_hold_reg; // low half latched at high half write
  reg [5:0] blk_low_hold_reg;
  reg [5:0] op_low_hold_reg; // op mode low half
  wire hi_op = word_done_reg && in_map && (word_addr_reg == `CCDREG_OP_MODE_HIGH);
  wire hi_vga = word_done_reg && in_map && (word_addr_reg == `CCDREG_VGA_GAIN_HIGH);
  wire hi_blk = word_done_reg && in_map && (word_addr_reg == `CCDREG_BLACK_LEVEL_HIGH);
  reg vga_ready_reg; // pair complete, waiting for sync commit
  reg blk_ready_reg;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vga_low_hold_reg <= 6'h05;
      blk_low_hold_reg <= 6'h00;
      op_low_hold_reg <= 6'h10;
      vga_ready_reg <= 1'b0;
      blk_ready_reg <= 1'b0;
    end else if (soft_reset_hit) begin
      vga_low_hold_reg <= 6'h05;
      blk_low_hold_reg <= 6'h00;
      op_low_hold_reg <= 6'h10;
      vga_ready_reg <= 1'b0;
      blk_ready_reg <= 1'b0;
    end else begin
      if (hi_op) begin
        op_low_hold_reg <= stage_reg[6'h00];
      end
      if (hi_vga) begin
        vga_low_hold_reg <= stage_reg[6'h02];
        vga_ready_reg <= 1'b1;
      end else if (sync_commit) begin
        vga_ready_reg <= 1'b0;
      end
      if (hi_blk) begin
        blk_low_hold_reg <= stage_reg[6'h04];
        blk_ready_reg <= 1'b1;
      end else if (sync_commit) begin
        blk_ready_reg <= 1'b0;
      end
    end
  end

  // sync-class committed outputs
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vga_gain <= `CCDREG_VGA_GAIN_RST;
      black_level <= `CCDREG_BLACK_LEVEL_RST;
      color_gain <= 24'h000000;
      data_out_phase <= 6'h00;
      output_gate <= 1'b0;
      data_clock_select <= 1'b0;
      input_clock_halve <= 1'b0;
      restore_disable <= 1'b0;
      line_field_out_select <= 1'b0;
      clamp_blank_out_select <= 1'b0;
      init_value_a <= 6'h00;
      init_value_b <= 6'h00;
    end else if (soft_reset_hit) begin
      vga_gain <= `CCDREG_VGA_GAIN_RST;
      black_level <= `CCDREG_BLACK_LEVEL_RST;
      color_gain <= 24'h000000;
      data_out_phase <= 6'h00;
      output_gate <= 1'b0;
      data_clock_select <= 1'b0;
      input_clock_halve <= 1'b0;
      restore_disable <= 1'b0;
      line_field_out_select <= 1'b0;
      clamp_blank_out_select <= 1'b0;
      init_value_a <= 6'h00;
      init_value_b <= 6'h00;
    end else if (sync_commit) begin
      if (vga_ready_reg) begin
        vga_gain <= {stage_reg[6'h03][3:0], vga_low_hold_reg};
      end
      if (blk_ready_reg) begin
        black_level <= {stage_reg[6'h05][1:0], blk_low_hold_reg};
      end
      color_gain <= {stage_reg[6'h0a], stage_reg[6'h09], stage_reg[6'h08], stage_reg[6'h07]};
      data_out_phase <= stage_reg[6'h1d];
      output_gate <= stage_reg[6'h18][0]; // 0 holds outputs inactive
      data_clock_select <= stage_reg[6'h1e][0]; // 0 phase-tracked, 1 inverted clock
      input_clock_halve <= stage_reg[6'h1f][0];
      restore_disable <= stage_reg[6'h20][0];
      line_field_out_select <= stage_reg[6'h27][0]; // 0 field, 1 line
      clamp_blank_out_select <= stage_reg[6'h28][0]; // 0 clamp, 1 blanking
      init_value_a <= stage_reg[6'h2b];
      init_value_b <= stage_reg[6'h10];
    end
  end

  // serial-load class: commit on the load rising edge
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      operation_mode <= `CCDREG_OP_MODE_RST;
      afe_control_mode <= 6'h00;
      field_parity_preset <= `CCDREG_FIELD_PARITY_RST;
      field_preset_pulse <= 1'b0;
      retime_pair_a <= 1'b0;
      retime_pair_b <= 1'b0;
      ext_sync_enable <= 1'b0;
      ext_sync_polarity <= 1'b0;
      ext_sync_suspend <= 1'b0;
      timing_core_run <= 1'b0;
      frame_transfer_mode <= 1'b0;
      shared_clamp <= `CCDREG_SHARED_CLAMP_RST;
      output_delay <= `CCDREG_OUTPUT_DELAY_RST;
      oscillator_enable <= `CCDREG_OSC_ENABLE_RST;
    end else begin
      field_preset_pulse <= 1'b0;
      if (sl_rise && sl_pend_reg) begin
        operation_mode <= {stage_reg[6'h01][1:0], op_low_hold_reg};
        afe_control_mode <= stage_reg[6'h06];
        field_parity_preset <= stage_reg[6'h21][0]; // 0 next odd, 1 next even
        field_preset_pulse <= dirty_reg[6'h21]; // reloads field indicator
        retime_pair_a <= stage_reg[6'h22][0];
        retime_pair_b <= stage_reg[6'h23][0];
        ext_sync_enable <= stage_reg[6'h24][0];
        ext_sync_polarity <= stage_reg[6'h25][0]; // 0 active low
        ext_sync_suspend <= stage_reg[6'h26][0];
        timing_core_run <= stage_reg[6'h29][0]; // 0 holds core in reset
        frame_transfer_mode <= stage_reg[6'h2a][0];
        shared_clamp <= stage_reg[6'h31][0]; // dummy clamp follows black clamp
        output_delay <= stage_reg[6'h32][1:0];
        oscillator_enable <= stage_reg[6'h33][0]; // 0 powers oscillator down
      end
    end
  end

  // substrate clear class: commit at line after sensor gate line
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      substrate_clear_cfg <= 6'h00;
    end else if (sub_pend_reg && sensor_gate_line_done) begin
      substrate_clear_cfg <= subclr_stage;
    end
  end

  // ****************************************************************
  // readback: staged word at current address, lsb first
  // ****************************************************************
  reg [2:0] rb_bit_reg; // bit index within readback word
  // limitation: readback drives only during data phase of the frame
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_bit_reg <= 3'h0;
      serial_data_out <= 1'b0;
      serial_data_out_en <= 1'b0;
    end else begin
      serial_data_out_en <= stage_reg[6'h1c][0] && sl_low && !addr_phase_reg;
      if (!sl_low || addr_phase_reg) begin
        rb_bit_reg <= 3'h0;
        serial_data_out <= 1'b0;
      end else begin
        serial_data_out <= addr_reg[9:6] == 4'h0 ? stage_reg[addr_reg[5:0]][rb_bit_reg] : 1'b0;
        if (sclk_rise) begin
          rb_bit_reg <= (rb_bit_reg == 3'd5) ? 3'h0 : rb_bit_reg + 3'h1;
        end
      end
    end
  end

endmodule

/* tb/ccdreg_bank_props.sv */
// concurrent checks on the ports of the control register bank
`timescale 1ns/1ps
module ccdreg_bank_props (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // serial pin and timing events
  input wire serial_load,
  input wire serial_data_out_en,
  input wire horizontal_sync_fall,
  input wire sensor_gate_line_done,
  input wire [5:0] subclr_stage,
  // committed values under watch
  input wire [5:0] substrate_clear_cfg,
  input wire [7:0] operation_mode,
  input wire [9:0] vga_gain,
  input wire output_gate,
  input wire timing_core_run,
  input wire [1:0] output_delay,
  input wire [5:0] init_value_a,
  input wire field_preset_pulse
);
  // ****************************************************************
  // clocking and named steps
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // load pin high long enough for the two-stage sync to see the rise
  sequence sl_commit_window;
    serial_load && $past(serial_load, 3);
  endsequence
  // frame closed: readback driver must have let go by now
  sequence load_closed;
    serial_load [*6];
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_opmode_on_load: assert property ($changed(operation_mode) |-> sl_commit_window)
    else $error("operation mode moved outside a load rise");
  chk_core_on_load: assert property ($changed(timing_core_run) |-> sl_commit_window)
    else $error("core run moved outside a load rise");
  chk_delay_on_load: assert property ($changed(output_delay) |-> sl_commit_window)
    else $error("output delay moved outside a load rise");
  chk_gain_on_sync: assert property ($changed(vga_gain) |-> $past(horizontal_sync_fall) || vga_gain == 10'h045)
    else $error("gain moved outside a sync point");
  chk_gate_on_sync: assert property ($changed(output_gate) |-> $past(horizontal_sync_fall) || !output_gate)
    else $error("output gate rose outside a sync point");
  chk_init_on_sync: assert property ($changed(init_value_a) |-> $past(horizontal_sync_fall) || init_value_a == 6'h00)
    else $error("init value moved outside a sync point");
  chk_subclr_after_gate: assert property ($changed(substrate_clear_cfg) |->
      ($past(sensor_gate_line_done) && substrate_clear_cfg == $past(subclr_stage)) || substrate_clear_cfg == 6'h00)
    else $error("substrate settings moved outside the gate line");
  chk_preset_one_pulse: assert property (field_preset_pulse |-> sl_commit_window ##1 !field_preset_pulse)
    else $error("field preset pulse malformed");
  chk_readback_release: assert property (load_closed |-> !serial_data_out_en)
    else $error("readback driver kept after frame end");
  // main scenarios reached
  cov_gate_commit: cover property ($rose(output_gate));
  cov_subclr_commit: cover property ($changed(substrate_clear_cfg));
endmodule

bind ccdreg_bank ccdreg_bank_props chk (.sys_clk(sys_clk), .reset_n(reset_n), .serial_load(serial_load),
  .serial_data_out_en(serial_data_out_en), .horizontal_sync_fall(horizontal_sync_fall),
  .sensor_gate_line_done(sensor_gate_line_done), .subclr_stage(subclr_stage),
  .substrate_clear_cfg(substrate_clear_cfg), .operation_mode(operation_mode), .vga_gain(vga_gain),
  .output_gate(output_gate), .timing_core_run(timing_core_run), .output_delay(output_delay),
  .init_value_a(init_value_a), .field_preset_pulse(field_preset_pulse));

/* tb/ccdreg_host_model.sv */
// host controller model driving the three-wire serial port
`timescale 1ns/1ps
module ccdreg_host_model (
  // sys clock, used only to pace the pins
  input wire sys_clk,
  // serial pins
  output logic serial_load,
  output logic serial_clock,
  output logic serial_data_in
);
  // serial clock half period in sys clocks; 4 or more keeps the sync ratio
  int half_cyc = 4;
  // idle pins: load high, clock parked low
  initial begin
    serial_load = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // one bit: data set up a half period before the rising clock
  task automatic tick(input logic b);
    serial_data_in = b;
    repeat (half_cyc) @(negedge sys_clk);
    serial_clock = 1'b1;
    repeat (half_cyc) @(negedge sys_clk);
    serial_clock = 1'b0;
  endtask
  // address then words back to back, low address word first
  task automatic frame(input logic [9:0] addr, input logic [65:0] data, input int nbits);
    @(negedge sys_clk);
    serial_load = 1'b0;
    for (int i = 0; i < 10; i++) tick(addr[i]);
    for (int i = 0; i < nbits; i++) tick(data[i]);
    repeat (half_cyc) @(negedge sys_clk);
    serial_load = 1'b1;
    // released line must not keep showing the last bit
    serial_data_in = ~serial_data_in;
    repeat (12) @(negedge sys_clk);
  endtask
endmodule

/* tb/test_ccdreg_bank.sv */
// self-checking bench for the control register bank
`timescale 1ns/1ps
`include "ccdreg_consts.vh"
module test_ccdreg_bank;
  `define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
  // ****************************************************************
  // signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsync_fall = 1'b0;
  logic sg_done = 1'b0;
  logic [11:0] line_count = 12'h000;
  logic [5:0] subclr_stage = 6'h2b;
  logic [5:0] rb_word = 6'h00; // readback bits, lsb first
  int checks = 0;
  int fail_count = 0;
  wire serial_load, serial_clock, serial_data_in, serial_data_out, serial_data_out_en, output_gate;
  wire data_clock_select, input_clock_halve, restore_disable, field_parity_preset, field_preset_pulse;
  wire retime_pair_a, retime_pair_b, ext_sync_enable, ext_sync_polarity, ext_sync_suspend;
  wire line_field_out_select, clamp_blank_out_select, timing_core_run, frame_transfer_mode;
  wire shared_clamp, oscillator_enable;
  wire [7:0] operation_mode, black_level;
  wire [9:0] vga_gain;
  wire [5:0] afe_control_mode, data_out_phase, init_value_a, init_value_b, substrate_clear_cfg;
  wire [23:0] color_gain;
  wire [1:0] output_delay;
  // ****************************************************************
  // design, host and clock
  // ****************************************************************
  ccdreg_host_model host (.sys_clk(sys_clk), .serial_load(serial_load), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in));
  ccdreg_bank dut (.sys_clk(sys_clk), .reset_n(reset_n), .serial_load(serial_load), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
    .horizontal_sync_fall(hsync_fall), .sensor_gate_line_done(sg_done), .line_count(line_count),
    .subclr_stage(subclr_stage), .substrate_clear_cfg(substrate_clear_cfg), .operation_mode(operation_mode),
    .vga_gain(vga_gain), .black_level(black_level), .afe_control_mode(afe_control_mode), .color_gain(color_gain),
    .data_out_phase(data_out_phase), .output_gate(output_gate), .data_clock_select(data_clock_select),
    .input_clock_halve(input_clock_halve), .restore_disable(restore_disable),
    .field_parity_preset(field_parity_preset), .field_preset_pulse(field_preset_pulse),
    .retime_pair_a(retime_pair_a), .retime_pair_b(retime_pair_b), .ext_sync_enable(ext_sync_enable),
    .ext_sync_polarity(ext_sync_polarity), .ext_sync_suspend(ext_sync_suspend),
    .line_field_out_select(line_field_out_select), .clamp_blank_out_select(clamp_blank_out_select),
    .timing_core_run(timing_core_run), .frame_transfer_mode(frame_transfer_mode), .shared_clamp(shared_clamp),
    .output_delay(output_delay), .oscillator_enable(oscillator_enable), .init_value_a(init_value_a),
    .init_value_b(init_value_b));
  // 100 MHz sys clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // host-side readback capture
  always @(posedge serial_clock) if (serial_data_out_en) rb_word <= {serial_data_out, rb_word[5:1]};
  // ****************************************************************
  // tasks
  // ****************************************************************
  // one sync point on the given line
  task sync(input logic [11:0] ln);
    @(negedge sys_clk);
    line_count = ln;
    hsync_fall = 1'b1;
    @(negedge sys_clk);
    hsync_fall = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // verdict and end of run
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well past the expected run of some 4100 cycles
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("op_mode", 8'h10, operation_mode)
    `CHK("vga", 10'h045, vga_gain)
    `CHK("black", 8'h80, black_level)
    `CHK("misc", 5'h1d, {field_parity_preset, shared_clamp, output_delay, oscillator_enable})
    // afe map in one auto-increment frame, low halves first
    host.frame(10'h000, {6'h04, 6'h03, 6'h02, 6'h01, 6'h15, 6'h01, 6'h11, 6'h02, 6'h3f, 6'h03, 6'h2a}, 66);
    `CHK("op_mode", 8'hea, operation_mode)
    `CHK("afe_ctl", 6'h15, afe_control_mode)
    `CHK("vga", 10'h045, vga_gain)
    sync(12'h000);
    `CHK("vga", 10'h0bf, vga_gain)
    `CHK("black", 8'h51, black_level)
    `CHK("color", 24'h103081, color_gain)
    // lone low half never commits
    host.frame(10'h002, 66'h00, 6);
    host.frame(10'h000, 66'h00, 6);
    sync(12'h000);
    `CHK("vga", 10'h0bf, vga_gain)
    `CHK("op_mode", 8'hea, operation_mode)
    // four bits only: word dropped
    host.frame(10'h006, 66'h2a, 4);
    `CHK("afe_ctl", 6'h15, afe_control_mode)
    // misc bits, with init value a following
    host.frame(10'h021, {6'h35, {9{6'h01}}, 6'h00}, 66);
    host.frame(10'h010, 66'h04, 6);
    `CHK("parity", 1'b0, field_parity_preset)
    `CHK("sl_bits", 7'h7f, {retime_pair_a, retime_pair_b, ext_sync_enable, ext_sync_polarity, ext_sync_suspend,
      timing_core_run, frame_transfer_mode})
    `CHK("out_sel", 2'h0, {line_field_out_select, clamp_blank_out_select})
    sync(12'h000);
    `CHK("out_sel", 2'h3, {line_field_out_select, clamp_blank_out_select})
    `CHK("init", 12'hd44, {init_value_a, init_value_b})
    host.frame(10'h031, 66'h000c0, 18);
    `CHK("clamp_dly", 4'h6, {shared_clamp, output_delay, oscillator_enable})
    // substrate settings wait for the gate line
    `CHK("subclr", 6'h00, substrate_clear_cfg)
    @(negedge sys_clk);
    sg_done = 1'b1;
    @(negedge sys_clk);
    sg_done = 1'b0;
    @(negedge sys_clk);
    `CHK("subclr", 6'h2b, substrate_clear_cfg)
    // hold blocks sync commits until cleared
    host.frame(10'h01b, 66'h01, 6);
    host.frame(10'h018, 66'h01, 6);
    sync(12'h000);
    `CHK("gate", 1'b0, output_gate)
    host.frame(10'h01b, 66'h00, 6);
    sync(12'h000);
    `CHK("gate", 1'b1, output_gate)
    // update line 5, slow host
    host.half_cyc = 9;
    host.frame(10'h019, 66'h005, 12);
    host.frame(10'h01e, 66'h01041, 18);
    host.half_cyc = 4;
    sync(12'h004);
    `CHK("clk_sel", 3'h0, {data_clock_select, input_clock_halve, restore_disable})
    sync(12'h005);
    `CHK("clk_sel", 3'h7, {data_clock_select, input_clock_halve, restore_disable})
    host.frame(10'h01c, 66'hb01, 12);
    host.frame(10'h01d, 66'h2c, 6);
    `CHK("readback", 6'h2c, rb_word)
    sync(12'h005);
    `CHK("dout_phase", 6'h2c, data_out_phase)
    // soft reset: sync class at once, load class at next load rise
    host.frame(10'h017, 66'h01, 6);
    `CHK("gate", 1'b0, output_gate)
    `CHK("vga", 10'h045, vga_gain)
    host.frame(10'h006, 66'h00, 6);
    `CHK("op_mode", 8'h10, operation_mode)
    `CHK("misc", 6'h2d, {field_parity_preset, timing_core_run, shared_clamp, output_delay, oscillator_enable})
    wrap_up();
  end
endmodule
